// >>> rtl/timer_if.sv
// Interface carrying the enable, prescale select and tick strobe between the prescaler and the timer core.
`timescale 1ns/1ps
interface timer_if;
    logic       enable;
    logic [2:0] prescale_sel;
    logic       tick;
    modport core (output enable, output prescale_sel, input tick);
    modport div  (input enable, input prescale_sel, output tick);
endinterface

// >>> rtl/timer_mode_engine.sv
// Sixteen-bit up-counting timer with comparator counter, PWM, compare and gated modes.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Comparator counter: written start count only for first pass, then restart at one.
// - Comparator counter counts chosen comparator edge; same bit sets initial output level.
// - PWM counts ticks up to reload value and toggles the output at match.
// - PWM reload: interrupt, count back to one, keep counting.
// - PWM polarity one: start high, low at match, high again at reload.
// - PWM polarity zero: start low, high at match, low again at reload.
// - PWM start count governs only first period; later periods start at one.
// - Compare mode counts prescaled clock from start value toward compare value.
// - Gated mode counts ticks only while the input pin is at the active level.
// - Gated mode interrupts on input going inactive and on every reload.
// - Gated reload interrupts, returns count to one, resumes only if input active.
// - Gated mode with output enabled inverts the output at each reload.
module timer_mode_engine (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_timer_in,
    input  wire logic        i_cmp_out,
    output logic             o_timer_out,
    output logic             o_timer_oe,
    output logic             o_irq
);
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] match;
    logic [15:0] reload;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        out_level;
    logic [1:0]  tin_sync;
    logic [1:0]  cmp_sync;
    logic        cmp_prev;
    logic        gate_prev;
    logic        enable;
    logic        pol;
    logic [1:0]  mode;
    logic        gate_active;
    logic        cmp_edge;
    logic        advance;
    logic        hit_reload;
    logic        hit_match;
    logic        gate_off;
    logic [15:0] next_count;
    logic [1:0]  clr_status;
    timer_if     tbus();

    // Write strobe aimed at one register index.
    function automatic logic wr_hit(input logic       wr,
                                    input logic [3:0] addr,
                                    input logic [3:0] target);
        return wr && (addr == target);
    endfunction

    // Sticky flag: the set wins over a clear that lands in the same cycle.
    function automatic logic sticky_next(input logic flag,
                                         input logic evt,
                                         input logic clear);
        return evt || (flag && !clear);
    endfunction

    assign enable = ctrl[timer_pkg::CTRL_EN_BIT];
    assign pol    = ctrl[timer_pkg::CTRL_POL_BIT];
    assign mode   = ctrl[timer_pkg::CTRL_MODE_LO +: 2];

    assign tbus.enable       = enable;
    assign tbus.prescale_sel = ctrl[timer_pkg::CTRL_PRE_LO +: 3];

    timer_prescaler u_prescaler (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .bus       (tbus.div)
    );

    // Pins from outside pass two flip-flops; only the second stage is read.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tin_sync <= 2'h0;
            cmp_sync <= 2'h0;
        end else begin
            tin_sync <= {tin_sync[0], i_timer_in};
            cmp_sync <= {cmp_sync[0], i_cmp_out};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmp_prev  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            cmp_prev  <= cmp_sync[1];
            gate_prev <= gate_active;
        end
    end

    assign gate_active = (tin_sync[1] == pol);
    // Polarity one picks the rising comparator edge, zero the falling one.
    assign cmp_edge = (cmp_sync[1] != cmp_prev) && (cmp_sync[1] == pol);

    always_comb begin
        unique case (mode)
            timer_pkg::MODE_CMP_CNT: advance = cmp_edge;
            timer_pkg::MODE_PWM:     advance = tbus.tick;
            timer_pkg::MODE_COMPARE: advance = tbus.tick;
            timer_pkg::MODE_GATED:   advance = tbus.tick && gate_active;
        endcase
    end

    assign hit_reload = enable && advance && (count == reload);
    assign hit_match  = enable && advance && (count == match) && (mode == timer_pkg::MODE_PWM);
    // A falling gate is only an event while the timer runs in gated mode.
    assign gate_off = enable && (mode == timer_pkg::MODE_GATED) && gate_prev && !gate_active;

    // The reload value is checked before incrementing, so a period is reload ticks long.
    always_comb begin
        if (hit_reload) begin
            next_count = timer_pkg::COUNT_RESTART;
        end else if (enable && advance) begin
            next_count = count + 16'h0001;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= timer_pkg::RESET_WORD;
        end else if (wr_hit(i_wr, i_addr, timer_pkg::ADDR_COUNT)) begin
            count <= i_wdata;
        end else begin
            count <= next_count;
        end
    end

    // Output level: preset from polarity while disabled, then driven by events.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_level <= 1'b0;
        end else if (!enable) begin
            out_level <= pol;
        end else if (mode == timer_pkg::MODE_PWM) begin
            if (hit_reload) begin
                out_level <= pol;
            end else if (hit_match) begin
                out_level <= !out_level;
            end
        end else if (hit_reload) begin
            out_level <= !out_level;
        end
    end

    assign o_timer_out = out_level;
    assign o_timer_oe  = ctrl[timer_pkg::CTRL_OE_BIT];

    // Control is taken whole; software keeps the timer disabled while it changes fields.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl <= timer_pkg::RESET_WORD;
        end else if (wr_hit(i_wr, i_addr, timer_pkg::ADDR_CTRL)) begin
            ctrl <= i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            match <= timer_pkg::RESET_WORD;
        end else if (wr_hit(i_wr, i_addr, timer_pkg::ADDR_MATCH)) begin
            match <= i_wdata;
        end
    end

    // The reload word doubles as the compare value in compare mode.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            reload <= timer_pkg::RESET_WORD;
        end else if (wr_hit(i_wr, i_addr, timer_pkg::ADDR_RELOAD)) begin
            reload <= i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask <= 2'h0;
        end else if (wr_hit(i_wr, i_addr, timer_pkg::ADDR_MASK)) begin
            mask <= i_wdata[1:0];
        end
    end

    assign clr_status = wr_hit(i_wr, i_addr, timer_pkg::ADDR_STATUS) ? i_wdata[1:0] : 2'h0;

    // Sticky events: a new event in the clearing cycle survives the clear.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status <= 2'h0;
        end else begin
            status[timer_pkg::ST_RELOAD] <= sticky_next(
                status[timer_pkg::ST_RELOAD],
                hit_reload,
                clr_status[timer_pkg::ST_RELOAD]);
            status[timer_pkg::ST_GATE_OFF] <= sticky_next(
                status[timer_pkg::ST_GATE_OFF],
                gate_off,
                clr_status[timer_pkg::ST_GATE_OFF]);
        end
    end

    assign o_irq = |(status & mask);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= timer_pkg::RESET_WORD;
        end else if (i_rd) begin
            unique case (i_addr)
                timer_pkg::ADDR_CTRL:   o_rdata <= ctrl;
                timer_pkg::ADDR_COUNT:  o_rdata <= count;
                timer_pkg::ADDR_MATCH:  o_rdata <= match;
                timer_pkg::ADDR_RELOAD: o_rdata <= reload;
                timer_pkg::ADDR_STATUS: o_rdata <= {14'h0000, status};
                timer_pkg::ADDR_MASK:   o_rdata <= {14'h0000, mask};
                // Pin levels let software tell a gate-off from a reload.
                timer_pkg::ADDR_PINS:   o_rdata <= {13'h0000, out_level,
                                                    cmp_sync[1], tin_sync[1]};
                default:                o_rdata <= timer_pkg::RESET_WORD;
            endcase
        end else begin
            o_rdata <= timer_pkg::RESET_WORD;
        end
    end
endmodule

// >>> rtl/timer_pkg.sv
// Package with register map, field layout, reset values and mode codes of the timer.
package timer_pkg;
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_COUNT   = 4'h1;
    localparam logic [3:0]  ADDR_MATCH   = 4'h2;
    localparam logic [3:0]  ADDR_RELOAD  = 4'h3;
    localparam logic [3:0]  ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_MASK    = 4'h5;
    localparam logic [3:0]  ADDR_PINS    = 4'h6;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_POL_BIT = 1;
    localparam int          CTRL_OE_BIT  = 2;
    localparam int          CTRL_MODE_LO = 4;
    localparam int          CTRL_PRE_LO  = 8;
    localparam int          ST_RELOAD    = 0;
    localparam int          ST_GATE_OFF  = 1;
    localparam logic [15:0] COUNT_RESTART = 16'h0001;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [1:0]  MODE_CMP_CNT = 2'h0;
    localparam logic [1:0]  MODE_PWM     = 2'h1;
    localparam logic [1:0]  MODE_COMPARE = 2'h2;
    localparam logic [1:0]  MODE_GATED   = 2'h3;
endpackage

// >>> rtl/timer_prescaler.sv
// Prescaler that divides the system clock by a power of two into one-cycle tick pulses.
`timescale 1ns/1ps
module timer_prescaler (
    input  wire logic i_ref_clk,
    input  wire logic i_nrst,
    timer_if.div      bus
);
    logic [6:0] count;
    logic [6:0] limit;

    assign limit = 7'((8'h01 << bus.prescale_sel) - 8'h01);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= 7'h00;
        end else if (!bus.enable || count >= limit) begin
            count <= 7'h00;
        end else begin
            count <= count + 7'h01;
        end
    end

    // A disabled timer restarts its prescale phase so the first period is whole.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus.tick <= 1'b0;
        end else begin
            bus.tick <= bus.enable && (count >= limit);
        end
    end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the timer: registers, PWM, gated, comparator and compare runs.
`timescale 1ns/1ps
module testbench;
    logic        clk, nrst, wr, rd, tin, cmp, tout, oe, irq;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, v, w;
    int          t1, t2, num_errors, samples_checked;
    timer_mode_engine dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer_in(tin), .i_cmp_out(cmp),
        .o_timer_out(tout), .o_timer_oe(oe), .o_irq(irq));
    timer_pins_model pins_u (.i_ref_clk(clk), .o_timer_in(tin), .o_cmp_out(cmp));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cfg(input logic [15:0] c, input logic [15:0] n, input logic [15:0] r);
        wr_reg(timer_pkg::ADDR_CTRL, c);
        wr_reg(timer_pkg::ADDR_COUNT, n);
        wr_reg(timer_pkg::ADDR_MATCH, 16'h0002);
        wr_reg(timer_pkg::ADDR_RELOAD, r);
        wr_reg(timer_pkg::ADDR_CTRL, c | 16'h0001);
    endtask
    task automatic halt;
        wr_reg(timer_pkg::ADDR_CTRL, 16'h0000);
        wr_reg(timer_pkg::ADDR_STATUS, 16'h0003);
    endtask
    task automatic wait_out(input logic l, output int n);
        n = 0;
        while (tout !== l && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 2000) begin
            num_errors++;
            $display("[FAIL] wait_out expected %h seen timeout", l);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        nrst  = 1'h0;
        wr    = 1'h0;
        rd    = 1'h0;
        addr  = 4'h0;
        wdata = 16'h0000;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        wr_reg(4'hF, 16'hFFFF);
        for (int a = 0; a < 16; a++) begin
            rd_reg(4'(a), v);
            chk("reset_word", 16'h0000, v);
        end
        wr_reg(timer_pkg::ADDR_MASK, 16'h0001);
        // Start count 5 only shortens the first period, which is not measured.
        for (int k = 0; k < 4; k++) begin
            cfg(16'h0014 | (k[1] ? 16'h0200 : 16'h0000) | (k[0] ? 16'h0002 : 16'h0000),
                16'h0005, 16'h0006);
            wait_out(!k[0], t1);
            wait_out(k[0], t1);
            wait_out(!k[0], t2);
            chk("pwm_after_match", 16'(4 << (2 * k[1])), 16'(t1));
            chk("pwm_to_match", 16'(2 << (2 * k[1])), 16'(t2));
            chk("pwm_irq", 16'h0001, {15'h0, irq});
            halt();
        end
        wr_reg(timer_pkg::ADDR_MASK, 16'h0002);
        cfg(16'h0036, 16'h0001, 16'h0004);
        pins_u.set_gate(1'h1);
        wait_out(1'h0, t1);
        wait_out(1'h1, t1);
        chk("gate_toggle", 16'h0004, 16'(t1));
        repeat (20) @(posedge clk);
        pins_u.set_gate(1'h0);
        repeat (8) @(posedge clk);
        chk("gate_irq", 16'h0001, {15'h0, irq});
        rd_reg(timer_pkg::ADDR_STATUS, v);
        chk("gate_status", 16'h0003, v);
        rd_reg(timer_pkg::ADDR_COUNT, v);
        repeat (10) @(posedge clk);
        rd_reg(timer_pkg::ADDR_COUNT, w);
        chk("gate_hold", v, w);
        rd_reg(timer_pkg::ADDR_PINS, v);
        chk("gate_cause", 16'h0000, {15'h0, v[0]});
        wr_reg(timer_pkg::ADDR_MASK, 16'h0000);
        halt();
        // Nine toggles give four edges of the chosen kind, so start 2 wraps once to 3.
        for (int p = 0; p < 2; p++) begin
            cfg(p ? 16'h0002 : 16'h0000, 16'h0002, 16'h0003);
            pins_u.cmp_edges(9);
            repeat (6) @(posedge clk);
            halt();
            rd_reg(timer_pkg::ADDR_COUNT, v);
            chk("cmp_count", 16'h0003, v);
        end
        cfg(16'h0120, 16'h0005, 16'hFF00);
        repeat (40) @(posedge clk);
        halt();
        rd_reg(timer_pkg::ADDR_COUNT, v);
        chk("compare_rate", 16'h0001, {15'h0, v > 16'h0014 && v < 16'h001C});
        chk("compare_count", 16'h0019, v);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule

// >>> verification/timer_mode_engine_assertions.sv
// Checker for bus, pin and interrupt relations at the timer ports.
`timescale 1ns/1ps
module timer_mode_engine_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic [3:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_timer_in,
    input wire logic        o_timer_out,
    input wire logic        o_timer_oe,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic ctl;
    assign ctl = i_wr && i_addr == timer_pkg::ADDR_CTRL;
    // Pin must sit still past the synchroniser before its echo can be trusted.
    sequence pin_quiet;
        $stable(i_timer_in)[*5] ##0 (i_rd && i_addr == timer_pkg::ADDR_PINS);
    endsequence
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not idle");
    a_unmapped_zero: assert property ((i_rd && i_addr > timer_pkg::ADDR_PINS) |=> !o_rdata)
        else $error("unmapped read not zero");
    a_oe_on: assert property ((ctl && i_wdata[2]) |-> ##2 o_timer_oe)
        else $error("output enable not set");
    a_oe_off: assert property ((ctl && !i_wdata[2]) |-> ##2 !o_timer_oe)
        else $error("output enable not clear");
    a_idle_high: assert property ((ctl && i_wdata[1:0] == 2'h2) |-> ##2 o_timer_out)
        else $error("idle output not high");
    a_idle_low: assert property ((ctl && i_wdata[1:0] == 2'h0) |-> ##2 !o_timer_out)
        else $error("idle output not low");
    a_irq_masked: assert property ((i_wr && i_addr == timer_pkg::ADDR_MASK && !i_wdata)
        |-> ##2 (!o_irq)[*3]) else $error("masked interrupt raised");
    a_pin_echo: assert property (pin_quiet |=> o_rdata[0] == $past(i_timer_in))
        else $error("pin echo wrong");
endmodule
bind timer_mode_engine timer_mode_engine_chk chk_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_timer_in(i_timer_in), .o_timer_out(o_timer_out), .o_timer_oe(o_timer_oe), .o_irq(o_irq));

// >>> verification/timer_pins_model.sv
// Model of the gate input pin and the comparator output beside the timer.
`timescale 1ns/1ps
module timer_pins_model (
    input  wire logic i_ref_clk,
    output logic      o_timer_in,
    output logic      o_cmp_out
);
    initial begin
        o_timer_in = 1'h0;
        o_cmp_out  = 1'h0;
    end
    task automatic set_gate(input logic l);
        @(posedge i_ref_clk);
        o_timer_in <= l;
    endtask
    // Edges are spaced wider than the synchroniser so that none merge.
    task automatic cmp_edges(input int n);
        repeat (n) begin
            repeat (6) @(posedge i_ref_clk);
            o_cmp_out <= ~o_cmp_out;
        end
    endtask
endmodule
